// ==== include/lgbc_cfg.svh ====
// Constants for the luma gamma, brightness monitor and clock output block.
`ifndef LGBC_CFG_SVH
`define LGBC_CFG_SVH

// Register subaddresses on the serial control port.
`define LGBC_ADDR_GAMMA     6'h26
`define LGBC_ADDR_BRIGHT    6'h34
`define LGBC_ADDR_OUTCLK    6'h35
`define LGBC_NUM_POINTS     14
`define LGBC_CURVE_POINTS   7
`define LGBC_READ_IDLE      8'h00

// Output clock control layout and reset value.
`define LGBC_OUTCLK_RESET   8'h70
`define LGBC_OUTCLK_EN_BIT  1

// Curve geometry.
`define LGBC_LOW_FIXED      8'h10
`define LGBC_HIGH_FIXED     8'hF0
`define LGBC_FIRST_KNOT     8'h20
`define LGBC_KNOT_STEP      32
`define LGBC_LAST_SEG       3'h7
`define LGBC_EDGE_SHIFT     4
`define LGBC_MID_SHIFT      5
`define LGBC_EDGE_HALF      16'sh0008
`define LGBC_MID_HALF       16'sh0010
`define LGBC_SAT_MAX        16'sh00FF
`define LGBC_SAT_MIN        16'sh0000

// Brightness accumulator sizes and divider steps.
`define LGBC_SUM_W          28
`define LGBC_CNT_W          20
`define LGBC_DIV_LAST_BIT   3'h7
`define LGBC_BRIGHT_RESET   8'h00

`endif

// ==== include/lgbc_pkg.sv ====
// Types shared by the luma gamma block modules.
`include "lgbc_cfg.svh"
package lgbc_pkg;
    typedef logic [7:0] lgbc_byte_t;
    typedef logic [`LGBC_NUM_POINTS-1:0][7:0] lgbc_points_t;
    typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} lgbc_div_state_t;
endpackage : lgbc_pkg

// ==== include/lgbc_luma_if.sv ====
// Interface carrying luma samples and curve points to the interpolator.
`timescale 1ns/1ns
interface lgbc_luma_if;
    import lgbc_pkg::*;
    lgbc_byte_t   lumaIn;
    logic         curveSelB;
    lgbc_points_t points;
    lgbc_byte_t   lumaOut;
    modport interp (input lumaIn, input curveSelB, input points, output lumaOut);
    modport owner  (output lumaIn, output curveSelB, output points, input lumaOut);
endinterface : lgbc_luma_if

// ==== design/lgbc_gamma_interp.sv ====
// Piecewise-linear gamma interpolator for the luma path, one register stage.
`timescale 1ns/1ns
`include "lgbc_cfg.svh"
module lgbc_gamma_interp (
    input wire logic  clock,
    input wire logic  reset,
    lgbc_luma_if.interp bus
);
    import lgbc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    lgbc_byte_t         knotY [9];
    logic [2:0]         seg;
    logic [3:0]         segNext;
    logic               edgeSeg;
    logic               fixedZone;
    lgbc_byte_t         x0;
    logic [4:0]         offset;
    logic signed [9:0]  diff;
    logic signed [15:0] prod;
    logic signed [15:0] rounded;
    logic signed [15:0] step;
    logic signed [15:0] yS;
    lgbc_byte_t         interp;
    lgbc_byte_t         next_luma;

    // Knot table: fixed ends and the seven knots of the selected curve.
    assign knotY[0] = `LGBC_LOW_FIXED;
    assign knotY[8] = `LGBC_HIGH_FIXED;
    for (genvar i = 0; i < `LGBC_CURVE_POINTS; i++) begin : g_knot
        assign knotY[i+1] = bus.curveSelB ? bus.points[i+`LGBC_CURVE_POINTS] : bus.points[i];
    end

    // Segment decode; the two edge segments are 16 wide, the rest 32.
    assign fixedZone = (bus.lumaIn < `LGBC_LOW_FIXED) || (bus.lumaIn >= `LGBC_HIGH_FIXED);
    assign seg       = (bus.lumaIn < `LGBC_FIRST_KNOT) ? 3'h0 : bus.lumaIn[7:5];
    assign segNext   = {1'b0, seg} + 4'h1;
    assign edgeSeg   = (seg == 3'h0) || (seg == `LGBC_LAST_SEG);
    assign x0        = (seg == 3'h0) ? `LGBC_LOW_FIXED : {seg, 5'h00};
    assign offset    = 5'(bus.lumaIn - x0);

    // Interpolation with round-half-up before the shift, then saturation.
    assign diff    = $signed({2'b00, knotY[segNext]}) - $signed({2'b00, knotY[seg]});
    assign prod    = 16'(diff) * 16'($signed({1'b0, offset}));
    assign rounded = prod + (edgeSeg ? `LGBC_EDGE_HALF : `LGBC_MID_HALF);
    assign step    = edgeSeg ? (rounded >>> `LGBC_EDGE_SHIFT) : (rounded >>> `LGBC_MID_SHIFT);
    assign yS      = $signed({8'h00, knotY[seg]}) + step;
    assign interp  = (yS < `LGBC_SAT_MIN) ? 8'h00 : (yS > `LGBC_SAT_MAX) ? 8'hFF : yS[7:0];
    assign next_luma = fixedZone ? bus.lumaIn : interp;

    // Output register of the luma path.
    always_ff @(posedge clock) begin
        if (reset) begin
            bus.lumaOut <= 8'h00;
        end else begin
            bus.lumaOut <= next_luma;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helper values for the checks below.
    lgbc_byte_t segLo;
    lgbc_byte_t segHi;
    assign segLo = (knotY[seg] < knotY[segNext]) ? knotY[seg] : knotY[segNext];
    assign segHi = (knotY[seg] < knotY[segNext]) ? knotY[segNext] : knotY[seg];

    a_fixed_ends: assert property (@(posedge clock) disable iff (reset)
        fixedZone |=> bus.lumaOut == $past(bus.lumaIn))
        else $error("Fixed curve point altered.");
    a_knot_exact: assert property (@(posedge clock) disable iff (reset)
        (bus.lumaIn == `LGBC_FIRST_KNOT) |=>
        bus.lumaOut == $past(bus.curveSelB ? bus.points[`LGBC_CURVE_POINTS] : bus.points[0]))
        else $error("First knot not reproduced exactly.");
    a_curve_b_knot: assert property (@(posedge clock) disable iff (reset)
        (bus.curveSelB && bus.lumaIn == 8'hE0) |=> bus.lumaOut == $past(bus.points[`LGBC_NUM_POINTS-1]))
        else $error("Curve B last knot not used.");
    a_interp_bounds: assert property (@(posedge clock) disable iff (reset)
        !fixedZone |=> (bus.lumaOut >= $past(segLo)) && (bus.lumaOut <= $past(segHi)))
        else $error("Interpolated value outside its segment.");
    c_curve_b_mid: cover property (@(posedge clock) disable iff (reset)
        bus.curveSelB && !fixedZone && !edgeSeg);
endmodule : lgbc_gamma_interp

// ==== design/lgbc_top.sv ====
// Luma gamma correction, field brightness monitor and output clock control.
`timescale 1ns/1ns
`include "lgbc_cfg.svh"
module lgbc_top (
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic         regWrite,
    input  wire logic [5:0]   regAddr,
    input  lgbc_pkg::lgbc_byte_t regWriteData,
    input  lgbc_pkg::lgbc_byte_t lumaIn,
    input  lgbc_pkg::lgbc_byte_t chromaIn,
    input  wire logic         activeVideo,
    input  wire logic         vsyncN,
    input  wire logic         curveSelectB,
    input  wire logic         pllDisable,
    input  wire logic         oversampleEnable,
    output lgbc_pkg::lgbc_byte_t regReadData,
    output lgbc_pkg::lgbc_byte_t lumaOut,
    output lgbc_pkg::lgbc_byte_t chromaOut,
    output logic              derivedClockOutEnable
);
    import lgbc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    lgbc_byte_t              gammaReg [`LGBC_NUM_POINTS];
    lgbc_byte_t              outClockCtrl;
    lgbc_byte_t              brightness;
    logic [`LGBC_SUM_W-1:0]  lumaSum;
    logic [`LGBC_CNT_W-1:0]  sampleCount;
    logic [`LGBC_SUM_W-1:0]  divRem;
    logic [`LGBC_CNT_W-1:0]  divCount;
    logic [2:0]              divBit;
    lgbc_byte_t              quotient;
    lgbc_div_state_t         divState;
    logic                    vsyncPrev;
    lgbc_luma_if             lumaBus ();

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode and read selection.
    logic [5:0] gammaIdx;
    logic       gammaHit;
    logic       outClkWrite;
    lgbc_byte_t readValue;
    assign gammaIdx    = regAddr - `LGBC_ADDR_GAMMA;
    assign gammaHit    = (regAddr >= `LGBC_ADDR_GAMMA) && (gammaIdx < 6'(`LGBC_NUM_POINTS));
    assign outClkWrite = regWrite && (regAddr == `LGBC_ADDR_OUTCLK);
    assign readValue   = gammaHit ? gammaReg[gammaIdx[3:0]] :
                         (regAddr == `LGBC_ADDR_BRIGHT) ? brightness :
                         (regAddr == `LGBC_ADDR_OUTCLK) ? outClockCtrl : `LGBC_READ_IDLE;

    // Curve registers, one per entry; reset gives an identity line.
    for (genvar i = 0; i < `LGBC_NUM_POINTS; i++) begin : g_point
        always_ff @(posedge clock) begin
            if (reset) begin
                gammaReg[i] <= 8'(((i % `LGBC_CURVE_POINTS) + 1) * `LGBC_KNOT_STEP);
            end else if (regWrite && gammaHit && (gammaIdx == 6'(i))) begin
                gammaReg[i] <= regWriteData;
            end
        end
        assign lumaBus.points[i] = gammaReg[i];
    end

    // Output clock control register and read data register.
    always_ff @(posedge clock) begin
        if (reset) begin
            outClockCtrl <= `LGBC_OUTCLK_RESET;
            regReadData  <= `LGBC_READ_IDLE;
        end else begin
            if (outClkWrite) begin
                outClockCtrl <= regWriteData;
            end
            regReadData <= readValue;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock output gate: honoured only with the PLL running and oversampling on.
    logic next_clockOutEnable;
    assign next_clockOutEnable = outClockCtrl[`LGBC_OUTCLK_EN_BIT] && !pllDisable && oversampleEnable;

    always_ff @(posedge clock) begin
        if (reset) begin
            derivedClockOutEnable <= 1'b0;
        end else begin
            derivedClockOutEnable <= next_clockOutEnable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Luma goes through the interpolator; chroma is only delayed to stay aligned.
    assign lumaBus.lumaIn    = lumaIn;
    assign lumaBus.curveSelB = curveSelectB;
    assign lumaOut           = lumaBus.lumaOut;

    lgbc_gamma_interp u_interp (
        .clock (clock),
        .reset (reset),
        .bus   (lumaBus.interp)
    );

    always_ff @(posedge clock) begin
        if (reset) begin
            chromaOut <= 8'h00;
        end else begin
            chromaOut <= chromaIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Field accumulation of active-video luma, restarted at every vsync fall.
    logic                   fieldEnd;
    logic [`LGBC_SUM_W-1:0] sampleWide;
    assign fieldEnd   = vsyncPrev && !vsyncN;
    assign sampleWide = `LGBC_SUM_W'(lumaIn);

    always_ff @(posedge clock) begin
        if (reset) begin
            vsyncPrev   <= 1'b1;
            lumaSum     <= '0;
            sampleCount <= '0;
        end else begin
            vsyncPrev <= vsyncN;
            if (fieldEnd) begin
                lumaSum     <= activeVideo ? sampleWide : '0;
                sampleCount <= activeVideo ? `LGBC_CNT_W'(1) : '0;
            end else if (activeVideo) begin
                lumaSum     <= lumaSum + sampleWide;
                sampleCount <= sampleCount + `LGBC_CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Restoring divider: sum over count, one quotient bit per cycle, MSB first.
    logic [`LGBC_SUM_W-1:0] shiftedDivisor;
    logic                   divFits;
    lgbc_byte_t             quotientNext;
    logic                   resultLoad;
    assign shiftedDivisor = `LGBC_SUM_W'(divCount) << divBit;
    assign divFits        = divRem >= shiftedDivisor;
    assign quotientNext   = quotient | (divFits ? (8'h01 << divBit) : 8'h00);
    assign resultLoad     = (divState == DIV_RUN) && (divBit == 3'h0);

    always_ff @(posedge clock) begin
        if (reset) begin
            divState   <= DIV_IDLE;
            divRem     <= '0;
            divCount   <= '0;
            divBit     <= `LGBC_DIV_LAST_BIT;
            quotient   <= 8'h00;
            brightness <= `LGBC_BRIGHT_RESET;
        end else begin
            case (divState)
                DIV_IDLE: begin
                    if (fieldEnd) begin
                        divRem   <= lumaSum;
                        divCount <= sampleCount;
                        divBit   <= `LGBC_DIV_LAST_BIT;
                        quotient <= 8'h00;
                        divState <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    if (divFits && divCount != '0) begin
                        divRem <= divRem - shiftedDivisor;
                    end
                    quotient <= (divCount != '0) ? quotientNext : 8'h00;
                    divBit   <= divBit - 3'h1;
                    if (resultLoad) begin
                        brightness <= (divCount != '0) ? quotientNext : 8'h00;
                        divState   <= DIV_IDLE;
                    end
                end
                default: begin
                    divState <= DIV_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the chroma path, the register file, the monitor and the clock gate.
    a_chroma_bypass: assert property (@(posedge clock) disable iff (reset)
        ##1 chromaOut == $past(chromaIn))
        else $error("Chroma was modified.");
    a_gamma_store: assert property (@(posedge clock) disable iff (reset)
        (regWrite && gammaHit) |=> gammaReg[$past(gammaIdx[3:0])] == $past(regWriteData))
        else $error("Curve register write lost.");
    a_bright_readonly: assert property (@(posedge clock) disable iff (reset)
        (regWrite && regAddr == `LGBC_ADDR_BRIGHT && !resultLoad) |=> $stable(brightness))
        else $error("Brightness register altered by a write.");
    a_bright_readback: assert property (@(posedge clock) disable iff (reset)
        (regAddr == `LGBC_ADDR_BRIGHT) |=> regReadData == $past(brightness))
        else $error("Brightness readback mismatch.");
    a_active_only: assert property (@(posedge clock) disable iff (reset)
        (!activeVideo && !fieldEnd) |=> $stable(lumaSum) && $stable(sampleCount))
        else $error("Blanking sample accumulated.");
    a_bright_update: assert property (@(posedge clock) disable iff (reset)
        (fieldEnd && divState == DIV_IDLE) |-> ##8 resultLoad)
        else $error("Brightness not loaded after vsync fall.");
    a_bright_only_field: assert property (@(posedge clock) disable iff (reset)
        !resultLoad |=> $stable(brightness))
        else $error("Brightness changed outside a field update.");
    a_derived_clock_output_pin_gate: assert property (@(posedge clock) disable iff (reset)
        derivedClockOutEnable == $past(outClockCtrl[`LGBC_OUTCLK_EN_BIT] && !pllDisable && oversampleEnable))
        else $error("Clock output enable wrong.");
    a_derived_clock_output_pin_blocked: assert property (@(posedge clock) disable iff (reset)
        (pllDisable || !oversampleEnable) |=> !derivedClockOutEnable)
        else $error("Clock output enabled without PLL and oversampling.");

    c_field_load: cover property (@(posedge clock) disable iff (reset) resultLoad && divCount != '0);
    c_derived_clock_output_pin_on: cover property (@(posedge clock) disable iff (reset) derivedClockOutEnable);
    c_gamma_write_b: cover property (@(posedge clock) disable iff (reset)
        regWrite && gammaHit && gammaIdx >= 6'(`LGBC_CURVE_POINTS));
endmodule : lgbc_top

// ==== sim/lgbc_host_model.sv ====
// Host model that programs and reads the block over its register port.
`timescale 1ns/1ns
`include "lgbc_cfg.svh"
module lgbc_host_model (
    input  wire logic           clock,
    output logic                regWrite,
    output logic [5:0]          regAddr,
    output lgbc_pkg::lgbc_byte_t regWriteData,
    input  lgbc_pkg::lgbc_byte_t regReadData
);
    import lgbc_pkg::*;

    // The port idles with no strobe.
    initial begin
        regWrite     = 1'b0;
        regAddr      = 6'h00;
        regWriteData = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Breakpoint output for power law g, kept inside the legal output span.
    function automatic lgbc_byte_t gamma_point(input int x, input real g);
        int y;
        y = $rtoi($pow((x - 16) / 224.0, g) * 224.0 + 16.5);
        if (y < 16) y = 16;
        if (y > 240) y = 240;
        return y[7:0];
    endfunction : gamma_point

    // One write strobe, then an idle edge so a following call never retimes the strobe in the same step.
    task automatic write_reg(input logic [5:0] addr, input lgbc_byte_t data);
        regWrite     = 1'b1;
        regAddr      = addr;
        regWriteData = data;
        @(posedge clock);
        #1;
        regWrite     = 1'b0;
        regWriteData = ~data;
        @(posedge clock);
        #1;
    endtask : write_reg

    // Present the address and take the registered answer one edge later.
    task automatic read_reg(input logic [5:0] addr, output lgbc_byte_t data);
        regAddr = addr;
        @(posedge clock);
        #1;
        data = regReadData;
    endtask : read_reg

    // Output clock write with the fixed bits at their required levels.
    task automatic write_outclk(input logic enable);
        write_reg(`LGBC_ADDR_OUTCLK, {1'b0, 3'h7, 2'h0, enable, 1'b0});
    endtask : write_outclk
endmodule : lgbc_host_model

// ==== sim/testbench.sv ====
// Self-checking bench for the luma gamma, brightness and clock output block.
`timescale 1ns/1ns
`include "lgbc_cfg.svh"
module testbench;
    import lgbc_pkg::*;
    logic       clock, reset, regWrite, activeVideo, vsyncN;
    logic       curveSelectB, pllDisable, oversampleEnable, derivedClockOutEnable;
    logic [5:0] regAddr;
    lgbc_byte_t regWriteData, regReadData, lumaIn, chromaIn, lumaOut, chromaOut, rd;
    lgbc_byte_t pts[0:13];
    int         badCount, cmpCount, sum, cnt, knotY[0:8];

    lgbc_top u_dut (.clock(clock), .reset(reset), .regWrite(regWrite), .regAddr(regAddr),
        .regWriteData(regWriteData), .lumaIn(lumaIn), .chromaIn(chromaIn), .activeVideo(activeVideo),
        .vsyncN(vsyncN), .curveSelectB(curveSelectB), .pllDisable(pllDisable),
        .oversampleEnable(oversampleEnable), .regReadData(regReadData), .lumaOut(lumaOut),
        .chromaOut(chromaOut), .derivedClockOutEnable(derivedClockOutEnable));
    lgbc_host_model u_host (.clock(clock), .regWrite(regWrite), .regAddr(regAddr),
        .regWriteData(regWriteData), .regReadData(regReadData));

    // The clock toggles every 10 ns, a period of 20 ns.
    always #10 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    // Compare one value and count it.
    task automatic check(input lgbc_byte_t got, input lgbc_byte_t exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Expected curve output from the knots held in knotY.
    function automatic lgbc_byte_t expect_luma(input int x);
        int i, x0, w, y;
        if (x < 16 || x >= 240) return x[7:0];
        i  = (x < 32) ? 0 : (x >= 224) ? 7 : x / 32;
        x0 = (i == 0) ? 16 : 32 * i;
        w  = (i == 0 || i == 7) ? 16 : 32;
        y  = knotY[i] + (((knotY[i+1] - knotY[i]) * (x - x0) + w / 2) >>> $clog2(w));
        if (y > 255) y = 255;
        if (y < 0) y = 0;
        return y[7:0];
    endfunction : expect_luma

    // Stream every input code through one curve and check both paths.
    task automatic sweep(input logic selB);
        curveSelectB = selB;
        knotY[0]     = 16;
        knotY[8]     = 240;
        for (int k = 1; k < 8; k++) knotY[k] = pts[selB * 7 + k - 1];
        @(posedge clock);
        #1;
        for (int x = 0; x < 256; x++) begin
            lumaIn   = x[7:0];
            chromaIn = 8'hFF - x[7:0];
            @(posedge clock);
            #1;
            check(lumaOut, expect_luma(x));
            check(chromaOut, 8'hFF - x[7:0]);
        end
    endtask : sweep

    // Feed one field with bright blanking samples, end it, then read the average.
    task automatic field(input int n, input logic act);
        sum = 0;
        cnt = 0;
        for (int i = 0; i < n; i++) begin
            activeVideo = act && (i % 4 != 0);
            lumaIn      = activeVideo ? 8'(40 + 5 * i) : 8'hFA;
            sum         = activeVideo ? sum + 40 + 5 * i : sum;
            cnt         = activeVideo ? cnt + 1 : cnt;
            @(posedge clock);
            #1;
        end
        activeVideo = 1'b0;
        vsyncN      = 1'b0;
        @(posedge clock);
        #1;
        vsyncN = 1'b1;
        repeat (10) @(posedge clock);
        #1;
        u_host.read_reg(`LGBC_ADDR_BRIGHT, rd);
        check(rd, (cnt == 0) ? 8'h00 : 8'(sum / cnt));
    endtask : field

    // Print the verdict and stop.
    task automatic results();
        if (badCount == 0 && cmpCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////
    // The whole run needs well under 2000 cycles, so this only trips on a hang.
    initial begin
        #200000;
        badCount++;
        results();
    end

    // Main sequence of register, luma, brightness and clock gate tests.
    initial begin
        clock            = 1'b0;
        reset            = 1'b1;
        lumaIn           = 8'h00;
        chromaIn         = 8'h00;
        activeVideo      = 1'b0;
        vsyncN           = 1'b1;
        curveSelectB     = 1'b0;
        pllDisable       = 1'b0;
        oversampleEnable = 1'b1;
        badCount         = 0;
        cmpCount         = 0;
        repeat (3) @(posedge clock);
        #1;
        reset = 1'b0;
        for (int k = 0; k < 14; k++) begin
            u_host.read_reg(6'(`LGBC_ADDR_GAMMA + k), rd);
            check(rd, 8'(32 * (k % 7 + 1)));
        end
        u_host.read_reg(`LGBC_ADDR_OUTCLK, rd);
        check(rd, `LGBC_OUTCLK_RESET);
        u_host.write_reg(`LGBC_ADDR_BRIGHT, 8'h5A);
        u_host.write_reg(6'h3F, 8'hA5);
        u_host.read_reg(`LGBC_ADDR_BRIGHT, rd);
        check(rd, 8'h00);
        u_host.read_reg(6'h3F, rd);
        check(rd, `LGBC_READ_IDLE);
        for (int k = 0; k < 14; k++) begin
            pts[k] = u_host.gamma_point(32 * (k % 7 + 1), (k < 7) ? 0.5 : 2.0);
            u_host.write_reg(6'(`LGBC_ADDR_GAMMA + k), pts[k]);
        end
        for (int k = 0; k < 14; k++) begin
            u_host.read_reg(6'(`LGBC_ADDR_GAMMA + k), rd);
            check(rd, pts[k]);
        end
        sweep(1'b0);
        sweep(1'b1);
        for (int k = 0; k < 8; k++) begin
            pllDisable       = k[1];
            oversampleEnable = k[2];
            u_host.write_outclk(k[0]);
            @(posedge clock);
            #1;
            check({7'h00, derivedClockOutEnable}, {7'h00, k[0] & ~k[1] & k[2]});
            u_host.read_reg(`LGBC_ADDR_OUTCLK, rd);
            check(rd, {4'h7, 2'h0, k[0], 1'b0});
        end
        field(12, 1'b0);
        field(20, 1'b1);
        repeat (3) u_host.read_reg(`LGBC_ADDR_BRIGHT, rd);
        check(rd, 8'(sum / cnt));
        field(9, 1'b1);
        results();
    end
endmodule : testbench
